// [rtl/pulse_ctrl_pkg.sv]
// Shared constants and types for the pulse-count LED current controller.
package pulse_ctrl_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned LATCH_TIMEOUT_US = 500;
  localparam int unsigned OFF_TIMEOUT_US   = 500;
  // Least times convert to whole cycles; the cycles-per-microsecond factor rounds down.
  localparam int unsigned LATCH_CYCLES =
    (LATCH_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned OFF_CYCLES =
    (OFF_TIMEOUT_US * (CLK_HZ / 1_000_000));

  localparam int unsigned CNT_W   = 6;
  localparam logic [5:0] DATA_MAX = 6'h10;
  localparam logic [5:0] ADDR_MAX = 6'h15;

  localparam logic [2:0] ADDR_BOTH  = 3'h1;
  localparam logic [2:0] ADDR_MAIN  = 3'h2;
  localparam logic [2:0] ADDR_SUB   = 3'h3;
  localparam logic [2:0] ADDR_SCALE = 3'h4;
  localparam logic [2:0] ADDR_LOW   = 3'h5;

  localparam logic [3:0] REG_RESET  = 4'h1;

  localparam logic [3:0] SCALE_20MA = 4'h1;
  localparam logic [3:0] SCALE_30MA = 4'h2;
  localparam logic [3:0] SCALE_15MA = 4'h3;
  localparam logic [3:0] SCALE_LOW  = 4'h4;

  // Register codes hold value minus one: code 16 stores as 4'hF.
  typedef struct packed {
    logic [3:0] main_code;
    logic [3:0] sub_code;
    logic [3:0] scale_code;
    logic [3:0] low_code;
  } regs_s;

  // Sink current in units of 0.05 mA (0 .. 600).
  typedef struct packed {
    logic [9:0] main_level;
    logic [9:0] sub_level;
  } levels_s;

  typedef enum logic [1:0] {
    MODE_1X,
    MODE_1P5X,
    MODE_2X
  } pump_mode_e;

endpackage

// [rtl/pin_sync.sv]
// Two-flop synchroniser for the control pin.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic sys_clk, // System clock.
  input  wire logic reset_n, // Synchronous reset, active low.
  input  wire logic d,       // Asynchronous input.
  output logic      q        // Synchronised level.
);
  logic meta;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// [rtl/level_lookup.sv]
// Registered lookup from a current code and scale to a sink level.
`timescale 1ns/1ps
module level_lookup (
  input  wire logic       sys_clk,   // System clock.
  input  wire logic       reset_n,   // Synchronous reset, active low.
  input  wire logic [3:0] code,      // Stored code, value minus one.
  input  wire logic [1:0] column,    // 0: 30 mA, 1: 20 mA, 2: 15 mA.
  output logic      [9:0] level      // Level in 0.05 mA units.
);
  logic [9:0] next_level;

  // Entries step down by about 1 dB; the last row is zero current.
  always_comb begin
    next_level = 10'h000;
    case ({column, code})
      6'h00: next_level = 10'd600; 6'h01: next_level = 10'd534;
      6'h02: next_level = 10'd476; 6'h03: next_level = 10'd428;
      6'h04: next_level = 10'd380; 6'h05: next_level = 10'd334;
      6'h06: next_level = 10'd304; 6'h07: next_level = 10'd266;
      6'h08: next_level = 10'd238; 6'h09: next_level = 10'd210;
      6'h0A: next_level = 10'd190; 6'h0B: next_level = 10'd172;
      6'h0C: next_level = 10'd152; 6'h0D: next_level = 10'd134;
      6'h0E: next_level = 10'd124;
      6'h10: next_level = 10'd400; 6'h11: next_level = 10'd356;
      6'h12: next_level = 10'd318; 6'h13: next_level = 10'd286;
      6'h14: next_level = 10'd254; 6'h15: next_level = 10'd222;
      6'h16: next_level = 10'd204; 6'h17: next_level = 10'd178;
      6'h18: next_level = 10'd158; 6'h19: next_level = 10'd140;
      6'h1A: next_level = 10'd126; 6'h1B: next_level = 10'd114;
      6'h1C: next_level = 10'd102; 6'h1D: next_level = 10'd88;
      6'h1E: next_level = 10'd82;
      6'h20: next_level = 10'd300; 6'h21: next_level = 10'd266;
      6'h22: next_level = 10'd238; 6'h23: next_level = 10'd214;
      6'h24: next_level = 10'd190; 6'h25: next_level = 10'd166;
      6'h26: next_level = 10'd152; 6'h27: next_level = 10'd134;
      6'h28: next_level = 10'd120; 6'h29: next_level = 10'd104;
      6'h2A: next_level = 10'd96;  6'h2B: next_level = 10'd86;
      6'h2C: next_level = 10'd76;  6'h2D: next_level = 10'd66;
      6'h2E: next_level = 10'd62;
      default: next_level = 10'h000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      level <= 10'h000;
    end else begin
      level <= next_level;
    end
  end
endmodule

// [rtl/pulse_count_led_current_ctrl.sv]
// Pulse-count control pin decoder, current registers and pump mode logic.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Address and data are chosen only by counting rising pin edges.
// - A burst is latched after the pin stays high for the latch timeout.
// - Seventeen to twenty-one edges select address count minus sixteen.
// - One to sixteen edges write data to the selected register.
// - Every data register holds four bits, sixteen codes.
// - Repeated data bursts go to the same address without resending it.
// - Pin low beyond the off timeout shuts the backlight down.
// - After shutdown the first edge selects address one.
// - Entering shutdown resets every data register to one.
// - Code one is full scale, fifteen minus 14 dB, sixteen is zero.
// - Codes two to fifteen are each about one decibel below the previous code.
// - Codes map through three columns: 30, 20 or 15 mA full scale.
// - Main group and sub group currents are set independently.
// - Pin activity enables the backlight converter.
// - Near dropout go to 1.5X first, then to 2X.
// - Any unused sink not tied to the rail forces 2X only.
// - Pulse sequences up to 1 MHz are supported.
// - Address 1 both, 2 main, 3 sub, 4 scale, 5 low current.
// - Scale 1 is 20 mA, 2 is 30 mA, 3 is 15 mA, 4 low mode.
// - Low mode takes both group currents from the low register.
module pulse_count_led_current_ctrl #(
  parameter int unsigned LATCH_CYCLES = pulse_ctrl_pkg::LATCH_CYCLES,
  parameter int unsigned OFF_CYCLES   = pulse_ctrl_pkg::OFF_CYCLES
) (
  input  wire logic       sys_clk,       // System clock, 50 MHz.
  input  wire logic       reset_n,       // Synchronous reset, active low.
  input  wire logic       ctrl_pin,      // Pulse control pin, asynchronous.
  input  wire logic [5:0] sink_near_dropout, // Per sink dropout warning.
  input  wire logic [5:0] sink_unterminated, // Unused sink not on rail.
  output logic            backlight_en,  // Backlight converter enabled.
  output pulse_ctrl_pkg::pump_mode_e pump_mode, // Converter gain mode.
  output pulse_ctrl_pkg::regs_s      regs,      // Stored register codes.
  output logic [2:0]      cur_addr,      // Selected address.
  output pulse_ctrl_pkg::levels_s    levels     // Sink levels, 0.05 mA.
);
  //////////////////////////////////////////////////////////////////////////
  localparam int unsigned TMR_W = 32;

  logic                          pin_s;
  logic                          pin_d;
  logic                          rise;
  logic [pulse_ctrl_pkg::CNT_W-1:0] edge_cnt;
  logic [TMR_W-1:0]              high_tmr;
  logic [TMR_W-1:0]              low_tmr;
  logic                          latch_now;
  logic                          off_now;
  logic [pulse_ctrl_pkg::CNT_W-1:0] cnt_minus_one;
  logic [pulse_ctrl_pkg::CNT_W-1:0] addr_full;
  logic [1:0]                    column;
  logic [9:0]                    main_tab;
  logic [9:0]                    sub_tab;
  logic                          low_mode;
  logic [9:0]                    low_main;
  logic [9:0]                    low_sub;
  logic [9:0]                    next_low_main;
  logic [9:0]                    next_low_sub;

  pin_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       (ctrl_pin),
    .q       (pin_s)
  );

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_d <= 1'b0;
    end else begin
      pin_d <= pin_s;
    end
  end

  // At 50 MHz a 1 MHz pulse stream is sampled many times per phase.
  assign rise = pin_s & ~pin_d;

  //////////////////////////////////////////////////////////////////////////
  // High and low time counters.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      high_tmr <= '0;
    end else if (!pin_s || rise) begin
      high_tmr <= '0;
    end else if (high_tmr < LATCH_CYCLES) begin
      high_tmr <= high_tmr + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      low_tmr <= '0;
    end else if (pin_s) begin
      low_tmr <= '0;
    end else if (low_tmr < OFF_CYCLES) begin
      low_tmr <= low_tmr + 32'h1;
    end
  end

  // Latch exactly once per high period, when the count is nonzero.
  assign latch_now = pin_s && (high_tmr == LATCH_CYCLES - 1) &&
                     (edge_cnt != '0);
  assign off_now   = !pin_s && (low_tmr == OFF_CYCLES - 1);

  // The count saturates so a very long burst still reads as out of range.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      edge_cnt <= '0;
    end else if (latch_now || off_now) begin
      edge_cnt <= '0;
    end else if (rise && edge_cnt != '1) begin
      edge_cnt <= edge_cnt + 6'h01;
    end
  end

  assign cnt_minus_one = edge_cnt - 6'h01;
  assign addr_full     = edge_cnt - pulse_ctrl_pkg::DATA_MAX;

  //////////////////////////////////////////////////////////////////////////
  // Enable and shutdown.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      backlight_en <= 1'b0;
    end else if (off_now) begin
      backlight_en <= 1'b0;
    end else if (rise) begin
      backlight_en <= 1'b1;
    end
  end

  // Shutdown returns the selection to address one for the next edge.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cur_addr <= pulse_ctrl_pkg::ADDR_BOTH;
    end else if (off_now) begin
      cur_addr <= pulse_ctrl_pkg::ADDR_BOTH;
    end else if (latch_now && edge_cnt > pulse_ctrl_pkg::DATA_MAX &&
                 edge_cnt <= pulse_ctrl_pkg::ADDR_MAX) begin
      cur_addr <= addr_full[2:0];
    end
  end

  // Codes are stored as value minus one so four bits hold 1..16.
  always_ff @(posedge sys_clk) begin
    if (!reset_n || off_now) begin
      regs.main_code  <= pulse_ctrl_pkg::REG_RESET - 4'h1;
      regs.sub_code   <= pulse_ctrl_pkg::REG_RESET - 4'h1;
      regs.scale_code <= pulse_ctrl_pkg::REG_RESET - 4'h1;
      regs.low_code   <= pulse_ctrl_pkg::REG_RESET - 4'h1;
    end else if (latch_now && edge_cnt <= pulse_ctrl_pkg::DATA_MAX) begin
      case (cur_addr)
        pulse_ctrl_pkg::ADDR_BOTH: begin
          regs.main_code <= cnt_minus_one[3:0];
          regs.sub_code  <= cnt_minus_one[3:0];
        end
        pulse_ctrl_pkg::ADDR_MAIN: regs.main_code <= cnt_minus_one[3:0];
        pulse_ctrl_pkg::ADDR_SUB:  regs.sub_code  <= cnt_minus_one[3:0];
        pulse_ctrl_pkg::ADDR_SCALE: regs.scale_code <= cnt_minus_one[3:0];
        pulse_ctrl_pkg::ADDR_LOW:  regs.low_code  <= cnt_minus_one[3:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Current decoding.
  // Scale values above 4 have no meaning; they keep the 20 mA column.
  always_comb begin
    case (regs.scale_code + 4'h1)
      pulse_ctrl_pkg::SCALE_30MA: column = 2'h0;
      pulse_ctrl_pkg::SCALE_15MA: column = 2'h2;
      default:                    column = 2'h1;
    endcase
  end

  assign low_mode = (regs.scale_code + 4'h1) == pulse_ctrl_pkg::SCALE_LOW;

  level_lookup u_main_lut (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .code    (regs.main_code),
    .column  (column),
    .level   (main_tab)
  );

  level_lookup u_sub_lut (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .code    (regs.sub_code),
    .column  (column),
    .level   (sub_tab)
  );

  // Low mode: bits 3:2 of code-1 pick which groups run, bits 1:0 the level.
  always_comb begin
    logic [9:0] lvl;
    lvl = 10'h000;
    case (regs.low_code[1:0])
      2'h0: lvl = 10'd1;
      2'h1: lvl = 10'd10;
      2'h2: lvl = 10'd20;
      default: lvl = 10'd40;
    endcase
    next_low_main = regs.low_code[3] ? lvl : 10'h000;
    next_low_sub  = regs.low_code[2] ? lvl : 10'h000;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      low_main <= 10'h000;
      low_sub  <= 10'h000;
    end else begin
      low_main <= next_low_main;
      low_sub  <= next_low_sub;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      levels <= '0;
    end else if (!backlight_en) begin
      levels <= '0;
    end else if (low_mode) begin
      levels.main_level <= low_main;
      levels.sub_level  <= low_sub;
    end else begin
      levels.main_level <= main_tab;
      levels.sub_level  <= sub_tab;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Converter mode: step up on dropout, never back down while enabled.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pump_mode <= pulse_ctrl_pkg::MODE_1X;
    end else if (!backlight_en) begin
      pump_mode <= pulse_ctrl_pkg::MODE_1X;
    end else if (|sink_unterminated) begin
      pump_mode <= pulse_ctrl_pkg::MODE_2X;
    end else if (|sink_near_dropout) begin
      case (pump_mode)
        pulse_ctrl_pkg::MODE_1X:   pump_mode <= pulse_ctrl_pkg::MODE_1P5X;
        pulse_ctrl_pkg::MODE_1P5X: pump_mode <= pulse_ctrl_pkg::MODE_2X;
        default:                   pump_mode <= pulse_ctrl_pkg::MODE_2X;
      endcase
    end
  end
endmodule

// [verification/pulse_ctrl_checker.sv]
// Port-level assertions for the pulse-count current controller.
`timescale 1ns/1ps
module pulse_ctrl_checker #(
  parameter int unsigned LATCH_CYCLES = 50,
  parameter int unsigned OFF_CYCLES   = 50
) (
  input wire logic                       sys_clk,           // Clock.
  input wire logic                       reset_n,           // Reset.
  input wire logic                       ctrl_pin,          // Control pin.
  input wire logic [5:0]                 sink_near_dropout, // Dropout.
  input wire logic [5:0]                 sink_unterminated, // Open sinks.
  input wire logic                       backlight_en,      // Enabled.
  input wire pulse_ctrl_pkg::pump_mode_e pump_mode,         // Pump mode.
  input wire pulse_ctrl_pkg::regs_s      regs,              // Codes.
  input wire logic [2:0]                 cur_addr,          // Address.
  input wire pulse_ctrl_pkg::levels_s    levels             // Levels.
);
  int lo_cnt;
  int hi_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////
  // Raw pin run lengths; the synchroniser only delays, so raw runs are
  // never shorter than what the design saw.
  always_ff @(posedge sys_clk) begin
    lo_cnt <= (!reset_n || ctrl_pin) ? 0 : lo_cnt + 1;
  end
  always_ff @(posedge sys_clk) begin
    hi_cnt <= (!reset_n || !ctrl_pin) ? 0 : hi_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////
  a_off_clears_regs: assert property ($fell(backlight_en) |-> ##[0:1]
    (regs == '0 && cur_addr == pulse_ctrl_pkg::ADDR_BOTH))
    else $error("registers not cleared on shutdown");
  a_off_needs_low: assert property ($fell(backlight_en) |->
    lo_cnt >= OFF_CYCLES) else $error("shutdown too early");
  a_off_forced: assert property (lo_cnt == OFF_CYCLES + 6 |->
    !backlight_en) else $error("no shutdown after long low");
  a_edge_wakes: assert property (!backlight_en && $rose(ctrl_pin)
    |-> ##[2:5] backlight_en) else $error("edge did not enable");
  a_latch_waits: assert property (backlight_en &&
    ($changed(regs) || $changed(cur_addr)) |-> hi_cnt >= LATCH_CYCLES)
    else $error("latch before timeout");
  a_pump_unterm: assert property (
    (backlight_en && |sink_unterminated) [*2] |->
    pump_mode == pulse_ctrl_pkg::MODE_2X) else $error("not forced to 2X");
  a_pump_first_step: assert property (backlight_en &&
    pump_mode == pulse_ctrl_pkg::MODE_1X && !(|sink_unterminated) |=>
    pump_mode != pulse_ctrl_pkg::MODE_2X) else $error("skipped 1.5X");
  a_levels_off: assert property (!backlight_en [*4] |->
    levels == '0) else $error("current while disabled");
endmodule
bind pulse_count_led_current_ctrl pulse_ctrl_checker #(
  .LATCH_CYCLES(LATCH_CYCLES), .OFF_CYCLES(OFF_CYCLES)
) pulse_ctrl_checker_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .ctrl_pin(ctrl_pin), .sink_near_dropout(sink_near_dropout),
  .sink_unterminated(sink_unterminated), .backlight_en(backlight_en),
  .pump_mode(pump_mode), .regs(regs), .cur_addr(cur_addr), .levels(levels));

// [verification/pulse_host.sv]
// Host model that drives the pulse control pin as a push-pull output.
`timescale 1ns/1ps
module pulse_host #(
  parameter int LATCH_CYCLES = 50,
  parameter int OFF_CYCLES   = 50,
  parameter int PHASE        = 25
) (
  input  wire logic sys_clk,  // Clock.
  output logic      ctrl_pin  // Control pin.
);
  initial ctrl_pin = 1'b0;
  // Phases of PHASE cycles give a 1 MHz edge rate at 50 MHz.
  task automatic burst(input int n);
    repeat (n) begin
      ctrl_pin = 1'b0;
      repeat (PHASE) @(negedge sys_clk);
      ctrl_pin = 1'b1;
      repeat (PHASE) @(negedge sys_clk);
    end
    repeat (LATCH_CYCLES + 10) @(negedge sys_clk);
  endtask
  task automatic off();
    ctrl_pin = 1'b0;
    repeat (OFF_CYCLES + 10) @(negedge sys_clk);
  endtask
endmodule

// [verification/test_pulse_count_led_current_ctrl.sv]
// Self-checking bench for the pulse-count current controller.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module test_pulse_count_led_current_ctrl;
  logic                       sys_clk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       ctrl_pin;
  logic [5:0]                 sink_near_dropout = 6'h00;
  logic [5:0]                 sink_unterminated = 6'h00;
  logic                       backlight_en;
  pulse_ctrl_pkg::pump_mode_e pump_mode;
  pulse_ctrl_pkg::regs_s      regs;
  logic [2:0]                 cur_addr;
  pulse_ctrl_pkg::levels_s    levels;
  pulse_ctrl_pkg::regs_s      er = '0;
  logic [2:0]                 ea = 3'h1;
  logic                       en = 1'b0;
  int                         error_cnt = 0;
  int                         checks = 0;
  int                         cyc = 0;
  int seq[12] = '{17, 16, 20, 4, 21, 13, 20, 2, 19, 5, 22, 1};
  int stp[4] = '{1, 10, 20, 40};
  int tbl[3][16] = '{
    '{600,534,476,428,380,334,304,266,238,210,190,172,152,134,124,0},
    '{400,356,318,286,254,222,204,178,158,140,126,114,102,88,82,0},
    '{300,266,238,214,190,166,152,134,120,104,96,86,76,66,62,0}};
  always #10 sys_clk = ~sys_clk;
  pulse_host pulse_host_inst (.sys_clk(sys_clk), .ctrl_pin(ctrl_pin));
  pulse_count_led_current_ctrl #(.LATCH_CYCLES(50), .OFF_CYCLES(50))
  pulse_count_led_current_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .ctrl_pin(ctrl_pin), .sink_near_dropout(sink_near_dropout),
    .sink_unterminated(sink_unterminated), .backlight_en(backlight_en),
    .pump_mode(pump_mode), .regs(regs), .cur_addr(cur_addr), .levels(levels));
  //////////////////////////////////////////////////////////////////////////
  // Stored codes are value minus one; scale code 3 is low-current mode.
  function automatic logic [9:0] exp_lvl(input logic [3:0] c, input bit sub);
    int col;
    if (!en) return 10'h000;
    if (er.scale_code == 4'h3)
      return (sub ? er.low_code[2] : er.low_code[3]) ?
        10'(stp[er.low_code[1:0]]) : 10'h000;
    col = (er.scale_code == 4'h1) ? 0 : (er.scale_code == 4'h2) ? 2 : 1;
    return 10'(tbl[col][c]);
  endfunction
  task automatic chk();
    `CHK("regs", er, regs)
    `CHK("cur_addr", ea, cur_addr)
    `CHK("backlight_en", en, backlight_en)
    `CHK("main_level", exp_lvl(er.main_code, 0), levels.main_level)
    `CHK("sub_level", exp_lvl(er.sub_code, 1), levels.sub_level)
  endtask
  task automatic wr(input int n);
    pulse_host_inst.burst(n);
    en = 1'b1;
    if (n >= 17 && n <= 21) ea = 3'(n - 16);
    else if (n <= 16) begin
      case (ea)
        3'h1: begin er.main_code = 4'(n - 1); er.sub_code = 4'(n - 1); end
        3'h2: er.main_code = 4'(n - 1);
        3'h3: er.sub_code = 4'(n - 1);
        3'h4: er.scale_code = 4'(n - 1);
        default: er.low_code = 4'(n - 1);
      endcase
    end
    chk();
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hCD2E076E));
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk();
    foreach (seq[i]) wr(seq[i]);
    for (int i = 0; i < 16; i++) begin
      if ($urandom_range(0, 1) == 1) wr($urandom_range(17, 21));
      wr($urandom_range(1, 16));
    end
    for (int i = 1; i < 3; i++) begin
      sink_near_dropout = 6'(1 << $urandom_range(0, 5));
      @(negedge sys_clk);
      sink_near_dropout = 6'h00;
      repeat (3) @(negedge sys_clk);
      `CHK("pump_mode", 2'(i), pump_mode)
    end
    pulse_host_inst.off();
    en = 1'b0;
    er = '0;
    ea = 3'h1;
    chk();
    `CHK("pump_mode", 2'h0, pump_mode)
    sink_unterminated = 6'(1 << $urandom_range(0, 5));
    wr(3);
    `CHK("pump_mode", 2'h2, pump_mode)
    sink_unterminated = 6'h00;
    end_of_test();
  end
endmodule
